// File: pkg/brc_pkg.sv
// Package: constants and carriers of the burst order and refresh configuration block
package brc_pkg;
  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int          ADDR_W        = 22;
  localparam int          DATA_W        = 16;
  localparam logic [21:0] LAST_WORD     = 22'h3fffff;
  localparam logic [21:0] ADDR_ZERO     = 22'h000000;
  localparam logic [21:0] SW_KEY_ADDR   = 22'h3fffff;
  localparam logic [15:0] SW_SEL_REFR   = 16'h0000;
  localparam logic [15:0] SW_SEL_BUS    = 16'h0001;
  // ************************************************************
  // Register fields
  // ************************************************************
  localparam int          SEL_BIT       = 19;
  localparam logic [15:0] REFR_RESET    = 16'h0070;
  localparam logic [15:0] REFR_MASK     = 16'h00f7;
  localparam logic [15:0] BUS_RESET     = 16'h9d4f;
  localparam int          PAGE_BIT      = 7;
  localparam int          TEMP_LSB      = 5;
  localparam int          PWR_BIT       = 4;
  localparam int          WIN_LSB       = 0;
  localparam int          WRAP_BIT      = 3;
  localparam int          BLEN_LSB      = 0;
  localparam int          LAT_LSB       = 11;
  localparam logic [2:0]  BLEN_4        = 3'h1;
  localparam logic [2:0]  BLEN_8        = 3'h2;
  localparam logic [2:0]  BLEN_16       = 3'h3;
  localparam logic [2:0]  BLEN_CONT     = 3'h7;
  localparam logic [1:0]  TEMP_85       = 2'h3;
  localparam logic [1:0]  TEMP_70       = 2'h0;
  localparam logic [1:0]  TEMP_45       = 2'h1;
  localparam logic [1:0]  TEMP_15       = 2'h2;
  localparam logic [2:0]  WIN_FULL      = 3'h0;
  localparam logic [2:0]  WIN_BOT_HALF  = 3'h1;
  localparam logic [2:0]  WIN_BOT_QTR   = 3'h2;
  localparam logic [2:0]  WIN_BOT_8TH   = 3'h3;
  localparam logic [2:0]  WIN_NONE      = 3'h4;
  localparam logic [2:0]  WIN_TOP_HALF  = 3'h5;
  localparam logic [2:0]  WIN_TOP_QTR   = 3'h6;
  localparam logic [2:0]  WIN_TOP_8TH   = 3'h7;
  localparam logic [21:0] TOP_HALF_BASE = 22'h200000;
  localparam logic [21:0] TOP_QTR_BASE  = 22'h300000;
  localparam logic [21:0] TOP_8TH_BASE  = 22'h380000;
  localparam logic [21:0] BOT_HALF_END  = 22'h1fffff;
  localparam logic [21:0] BOT_QTR_END   = 22'h0fffff;
  localparam logic [21:0] BOT_8TH_END   = 22'h07ffff;
  localparam int          FIFO_DEPTH    = 8;
  localparam logic [4:0]  LEN_4         = 5'h04;
  localparam logic [4:0]  LEN_8         = 5'h08;
  localparam logic [4:0]  LEN_16        = 5'h10;

  typedef struct packed {
    logic        page_en;
    logic [1:0]  temp;
    logic        active;
    logic        refresh_on;
    logic [21:0] win_lo;
    logic [21:0] win_hi;
  } brc_refresh_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [21:0] addr;
  } brc_burst_s;
endpackage : brc_pkg

// File: hdl/brc_fifo.sv
// Small valid/ready FIFO holding burst word addresses
`timescale 1ns/1ps
module brc_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic [WIDTH-1:0] dout;
    logic          ov;
  } brc_fifo_s;

  logic [WIDTH-1:0] mem [DEPTH];
  brc_fifo_s        st_q;
  brc_fifo_s        st_d;
  logic             push;
  logic             pop;
  logic             load;

  // Output register refilled whenever empty or consumed
  always_comb begin
    st_d     = st_q;
    in_ready = (st_q.cnt != (AW+1)'(DEPTH));
    push     = in_valid && in_ready;
    load     = (st_q.cnt != '0) && (!st_q.ov || out_ready);
    pop      = load;
    if (st_q.ov && out_ready) begin
      st_d.ov = 1'b0;
    end
    if (load) begin
      st_d.dout = mem[st_q.rp];
      st_d.ov   = 1'b1;
      st_d.rp   = st_q.rp + 1'b1;
    end
    if (push) begin
      st_d.wp = st_q.wp + 1'b1;
    end
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_q.wp] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign out_data  = st_q.dout;
  assign out_valid = st_q.ov;
endmodule : brc_fifo

// File: hdl/brc_config.sv
// Configuration registers, burst address sequencer and refresh window decode
//
// Functional notes
// - Burst length code 111 means continuous; it is the reset value.
// - Write bursts always run continuous regardless of burst length code.
// - Wrap, fixed length: addresses step up, wrap inside aligned group.
// - No-wrap, fixed length: length words at increasing addresses, crossing groups.
// - Continuous: linear increment, wrap bit ignored.
// - Refresh register resets to 0070h.
// - Refresh bit 7 enables asynchronous page reads when one.
// - Refresh bits 6-5 select temperature threshold, 11 default 85 degrees.
// - Writing bit 4 low enters deep sleep until written high.
// - Window codes 001/010/011 refresh bottom half, quarter, eighth.
// - Window 000 refreshes whole array; 100 refreshes nothing.
// - Window codes 101/110/111 refresh top half, quarter, eighth.
// - Windows apply only while bit 4 is one; else no refresh.
// - Address bit 19 selects refresh (0) or bus (1) register.
// - Config enable high: write captures address lines 0-15.
// - Two reads and key write to top address open a register access.
// - Continuous burst rolls past last word to address zero.
`timescale 1ns/1ps
module brc_config (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        cfg_en,
  input  wire logic        acc_strobe,
  input  wire logic        acc_write,
  input  wire logic [21:0] acc_addr,
  input  wire logic [15:0] acc_wdata,
  output logic      [15:0] acc_rdata,
  input  wire logic        burst_start,
  input  wire logic        burst_write,
  input  wire logic [21:0] burst_addr,
  input  wire logic        burst_stop,
  output logic             burst_busy,
  output logic      [21:0] word_addr,
  output logic             word_valid,
  input  wire logic        word_ready,
  output logic             word_write,
  output logic             page_read_enable_bit,
  output logic      [1:0]  refresh_temp_threshold,
  output logic             deep_sleep,
  output logic             refresh_active,
  output logic      [21:0] refresh_lo,
  output logic      [21:0] refresh_hi,
  output logic      [1:0]  latency_code,
  output logic             wrap_select_bit,
  output logic      [2:0]  burst_length_field
);
  // ************************************************************
  // Reset and pin synchronisers
  // ************************************************************
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic [1:0]  cfg_s_q;
  logic [1:0]  stb_s_q;
  logic [1:0]  wr_s_q;
  logic [1:0]  bst_s_q;
  logic [1:0]  bw_s_q;
  logic [1:0]  stp_s_q;
  logic [21:0] addr_s1_q;
  logic [21:0] addr_s2_q;
  logic [21:0] badr_s1_q;
  logic [21:0] badr_s2_q;
  logic [15:0] wd_s1_q;
  logic [15:0] wd_s2_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_s_q   <= 2'h0;
      stb_s_q   <= 2'h0;
      wr_s_q    <= 2'h0;
      bst_s_q   <= 2'h0;
      bw_s_q    <= 2'h0;
      stp_s_q   <= 2'h0;
      addr_s1_q <= 22'h000000;
      addr_s2_q <= 22'h000000;
      badr_s1_q <= 22'h000000;
      badr_s2_q <= 22'h000000;
      wd_s1_q   <= 16'h0000;
      wd_s2_q   <= 16'h0000;
    end else begin
      cfg_s_q   <= {cfg_s_q[0], cfg_en};
      stb_s_q   <= {stb_s_q[0], acc_strobe};
      wr_s_q    <= {wr_s_q[0], acc_write};
      bst_s_q   <= {bst_s_q[0], burst_start};
      bw_s_q    <= {bw_s_q[0], burst_write};
      stp_s_q   <= {stp_s_q[0], burst_stop};
      addr_s1_q <= acc_addr;
      addr_s2_q <= addr_s1_q;
      badr_s1_q <= burst_addr;
      badr_s2_q <= badr_s1_q;
      wd_s1_q   <= acc_wdata;
      wd_s2_q   <= wd_s1_q;
    end
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [4:0] brc_len(input logic [2:0] code);
    case (code)
      brc_pkg::BLEN_4:  brc_len = brc_pkg::LEN_4;
      brc_pkg::BLEN_8:  brc_len = brc_pkg::LEN_8;
      brc_pkg::BLEN_16: brc_len = brc_pkg::LEN_16;
      default:          brc_len = 5'h00;
    endcase
  endfunction : brc_len

  function automatic brc_pkg::brc_refresh_s brc_window(input logic [15:0] r);
    brc_window            = '0;
    brc_window.page_en    = r[brc_pkg::PAGE_BIT];
    brc_window.temp       = r[brc_pkg::TEMP_LSB +: 2];
    brc_window.active     = r[brc_pkg::PWR_BIT];
    brc_window.refresh_on = r[brc_pkg::PWR_BIT];
    brc_window.win_lo     = brc_pkg::ADDR_ZERO;
    brc_window.win_hi     = brc_pkg::LAST_WORD;
    case (r[brc_pkg::WIN_LSB +: 3])
      brc_pkg::WIN_FULL:     ;
      brc_pkg::WIN_BOT_HALF: brc_window.win_hi = brc_pkg::BOT_HALF_END;
      brc_pkg::WIN_BOT_QTR:  brc_window.win_hi = brc_pkg::BOT_QTR_END;
      brc_pkg::WIN_BOT_8TH:  brc_window.win_hi = brc_pkg::BOT_8TH_END;
      brc_pkg::WIN_NONE:     brc_window.refresh_on = 1'b0;
      brc_pkg::WIN_TOP_HALF: brc_window.win_lo = brc_pkg::TOP_HALF_BASE;
      brc_pkg::WIN_TOP_QTR:  brc_window.win_lo = brc_pkg::TOP_QTR_BASE;
      brc_pkg::WIN_TOP_8TH:  brc_window.win_lo = brc_pkg::TOP_8TH_BASE;
      default:               brc_window.refresh_on = 1'b0;
    endcase
    if (!brc_window.refresh_on) begin
      brc_window.win_lo = brc_pkg::ADDR_ZERO;
      brc_window.win_hi = brc_pkg::ADDR_ZERO;
    end
  endfunction : brc_window

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [1:0] {
    BRC_IDLE,
    BRC_RUN
  } brc_seq_e;

  typedef struct packed {
    logic [15:0]  refr;
    logic [15:0]  bus;
    logic [1:0]   key_cnt;
    logic         key_open;
    logic         key_sel;
    logic [15:0]  rdata;
    logic         stb_prev;
    logic         bst_prev;
    brc_seq_e     seq;
    logic [21:0]  cur;
    logic [21:0]  base;
    logic [4:0]   left;
    logic         cont;
    logic         wrap;
    logic         wr;
    brc_pkg::brc_refresh_s rf;
  } brc_config_s;

  brc_config_s st_q;
  brc_config_s st_d;
  logic        stb_rise;
  logic        bst_rise;
  logic [4:0]  blen;
  logic [22:0] fifo_in;
  logic        fifo_in_ready;
  logic [22:0] fifo_out;
  logic        fifo_out_valid;
  logic [21:0] wmask;
  logic [21:0] nxt;

  brc_fifo #(
    .WIDTH (23),
    .DEPTH (brc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (mclk),
    .rst_n     (rst_n),
    .in_data   (fifo_in),
    .in_valid  (st_q.seq == BRC_RUN),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (word_ready || !word_valid)
  );

  assign fifo_in = {st_q.wr, st_q.cur};

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_d     = st_q;
    stb_rise = stb_s_q[1] && !st_q.stb_prev;
    bst_rise = bst_s_q[1] && !st_q.bst_prev;
    blen     = brc_len(st_q.bus[brc_pkg::BLEN_LSB +: 3]);
    wmask    = 22'(blen) - 22'h1;
    nxt      = 22'h0;
    st_d.stb_prev = stb_s_q[1];
    st_d.bst_prev = bst_s_q[1];

    // Register access; hardware path wins over the keyed sequence
    if (stb_rise) begin
      if (cfg_s_q[1]) begin
        if (wr_s_q[1]) begin
          if (addr_s2_q[brc_pkg::SEL_BIT]) begin
            st_d.bus = addr_s2_q[15:0];
          end else begin
            st_d.refr = addr_s2_q[15:0] & brc_pkg::REFR_MASK;
          end
        end else begin
          st_d.rdata = addr_s2_q[brc_pkg::SEL_BIT] ? st_q.bus
                                                   : (st_q.refr & brc_pkg::REFR_MASK);
        end
        st_d.key_cnt  = 2'h0;
        st_d.key_open = 1'b0;
      end else if (st_q.key_open) begin
        if (wr_s_q[1]) begin
          if (st_q.key_sel) begin
            st_d.bus = wd_s2_q;
          end else begin
            st_d.refr = wd_s2_q & brc_pkg::REFR_MASK;
          end
        end else begin
          st_d.rdata = st_q.key_sel ? st_q.bus : (st_q.refr & brc_pkg::REFR_MASK);
        end
        st_d.key_open = 1'b0;
        st_d.key_cnt  = 2'h0;
      end else if (addr_s2_q == brc_pkg::SW_KEY_ADDR) begin
        if (!wr_s_q[1] && st_q.key_cnt != 2'h2) begin
          st_d.key_cnt = st_q.key_cnt + 2'h1;
        end else if (wr_s_q[1] && st_q.key_cnt == 2'h2 &&
                     (wd_s2_q == brc_pkg::SW_SEL_REFR || wd_s2_q == brc_pkg::SW_SEL_BUS)) begin
          st_d.key_open = 1'b1;
          st_d.key_sel  = (wd_s2_q == brc_pkg::SW_SEL_BUS);
          st_d.key_cnt  = 2'h0;
        end else begin
          st_d.key_cnt = 2'h0;
        end
      end else begin
        st_d.key_cnt = 2'h0;
      end
    end

    // Burst address sequencer
    case (st_q.seq)
      BRC_IDLE: begin
        if (bst_rise) begin
          st_d.seq  = BRC_RUN;
          st_d.cur  = badr_s2_q;
          st_d.base = badr_s2_q & ~wmask;
          st_d.wr   = bw_s_q[1];
          st_d.cont = bw_s_q[1] || (blen == 5'h00);
          st_d.wrap = !st_q.bus[brc_pkg::WRAP_BIT];
          st_d.left = blen;
        end
      end
      BRC_RUN: begin
        if (stp_s_q[1]) begin
          st_d.seq = BRC_IDLE;
        end else if (fifo_in_ready) begin
          if (st_q.cont) begin
            nxt = (st_q.cur == brc_pkg::LAST_WORD) ? brc_pkg::ADDR_ZERO
                                                   : st_q.cur + 22'h1;
          end else if (st_q.wrap) begin
            nxt = st_q.base | ((st_q.cur + 22'h1) & wmask);
          end else begin
            nxt = st_q.cur + 22'h1;
          end
          st_d.cur = nxt;
          if (!st_q.cont) begin
            st_d.left = st_q.left - 5'h1;
            if (st_q.left == 5'h01) begin
              st_d.seq = BRC_IDLE;
            end
          end
        end
      end
      default: st_d.seq = BRC_IDLE;
    endcase

    st_d.rf = brc_window(st_d.refr);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= '0;
      st_q.refr <= brc_pkg::REFR_RESET;
      st_q.bus  <= brc_pkg::BUS_RESET;
      st_q.seq  <= BRC_IDLE;
      st_q.rf   <= brc_window(brc_pkg::REFR_RESET);
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      word_valid <= 1'b0;
      word_addr  <= 22'h000000;
      word_write <= 1'b0;
    end else if (word_ready || !word_valid) begin
      word_valid <= fifo_out_valid;
      word_addr  <= fifo_out[21:0];
      word_write <= fifo_out[22];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_rdata              <= 16'h0000;
      burst_busy             <= 1'b0;
      page_read_enable_bit   <= 1'b0;
      refresh_temp_threshold <= brc_pkg::TEMP_85;
      deep_sleep             <= 1'b0;
      refresh_active         <= 1'b1;
      refresh_lo             <= brc_pkg::ADDR_ZERO;
      refresh_hi             <= brc_pkg::LAST_WORD;
      // Same as the stored bus register reset, so nothing steps on release
      latency_code           <= brc_pkg::BUS_RESET[brc_pkg::LAT_LSB +: 2];
      wrap_select_bit        <= brc_pkg::BUS_RESET[brc_pkg::WRAP_BIT];
      burst_length_field     <= brc_pkg::BLEN_CONT;
    end else begin
      acc_rdata              <= st_q.rdata;
      burst_busy             <= (st_q.seq == BRC_RUN);
      page_read_enable_bit   <= st_q.rf.page_en;
      refresh_temp_threshold <= st_q.rf.temp;
      deep_sleep             <= !st_q.rf.active;
      refresh_active         <= st_q.rf.refresh_on;
      refresh_lo             <= st_q.rf.win_lo;
      refresh_hi             <= st_q.rf.win_hi;
      latency_code           <= st_q.bus[brc_pkg::LAT_LSB +: 2];
      wrap_select_bit        <= st_q.bus[brc_pkg::WRAP_BIT];
      burst_length_field     <= st_q.bus[brc_pkg::BLEN_LSB +: 3];
    end
  end
endmodule : brc_config

// File: testbench/brc_config_properties.sv
// Checker for the burst order and refresh configuration block
`timescale 1ns/1ps
module brc_config_properties (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        burst_busy,
  input wire logic [21:0] word_addr,
  input wire logic        word_valid,
  input wire logic        word_ready,
  input wire logic        word_write,
  input wire logic        deep_sleep,
  input wire logic        refresh_active,
  input wire logic [21:0] refresh_lo,
  input wire logic [21:0] refresh_hi,
  input wire logic [1:0]  latency_code,
  input wire logic        wrap_select_bit,
  input wire logic [2:0]  burst_length_field
);
  logic [21:0] prev_q;
  logic        have_q;
  logic        busy_q;
  logic [4:0]  cnt_q;
  logic [21:0] m;
  logic        acc;
  logic        fix;
  assign acc = word_valid && word_ready;
  assign fix = !word_write && burst_length_field inside {3'h1, 3'h2, 3'h3};
  assign m   = (burst_length_field == 3'h1) ? 22'h3 : (burst_length_field == 3'h2) ? 22'h7 : 22'hf;
  // Last accepted word; forgotten at each new burst
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= 22'h0;
      have_q <= 1'b0;
      busy_q <= 1'b0;
      cnt_q  <= 5'h0;
    end else begin
      busy_q <= burst_busy;
      if (burst_busy && !busy_q) begin
        have_q <= 1'b0;
        cnt_q  <= 5'h0;
      end else if (acc) begin
        prev_q <= word_addr;
        have_q <= 1'b1;
        cnt_q  <= cnt_q + 5'h1;
      end
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence stall_s; word_valid && !word_ready; endsequence
  sequence step_s; acc && have_q; endsequence
  a_word_hold: assert property (stall_s |=> word_valid && $stable(word_addr) && $stable(word_write))
    else $error("word changed while stalled");
  a_linear_step: assert property (step_s ##0 (!fix || wrap_select_bit) |-> word_addr == prev_q + 22'h1)
    else $error("linear burst skipped a word");
  a_wrap_group: assert property (step_s ##0 (fix && !wrap_select_bit) |->
    (word_addr & ~m) == (prev_q & ~m) && (word_addr & m) == ((prev_q + 22'h1) & m))
    else $error("wrapped burst left its group");
  a_fixed_count: assert property (acc && fix |-> cnt_q < (5'h2 << burst_length_field))
    else $error("fixed burst too long");
  a_sleep_quiet: assert property (deep_sleep |-> !refresh_active && refresh_lo == 22'h0 && refresh_hi == 22'h0)
    else $error("refresh while in deep sleep");
  a_top_window: assert property (refresh_active && refresh_lo != 22'h0 |-> refresh_hi == 22'h3fffff &&
    refresh_lo inside {22'h200000, 22'h300000, 22'h380000})
    else $error("bad top window");
  a_bottom_window: assert property (refresh_active && refresh_lo == 22'h0 |->
    refresh_hi inside {22'h3fffff, 22'h1fffff, 22'h0fffff, 22'h07ffff})
    else $error("bad bottom window");
  a_reset_state: assert property (disable iff (1'b0) !rst_b [*2] |-> burst_length_field == 3'h7 &&
    wrap_select_bit && latency_code == 2'h3 && !deep_sleep && refresh_active && refresh_hi == 22'h3fffff && !word_valid)
    else $error("wrong state in reset");
endmodule : brc_config_properties

bind brc_config brc_config_properties chk_u (.mclk(mclk), .rst_b(rst_b), .burst_busy(burst_busy),
  .word_addr(word_addr), .word_valid(word_valid), .word_ready(word_ready), .word_write(word_write),
  .deep_sleep(deep_sleep), .refresh_active(refresh_active), .refresh_lo(refresh_lo), .refresh_hi(refresh_hi),
  .latency_code(latency_code), .wrap_select_bit(wrap_select_bit), .burst_length_field(burst_length_field));

// File: testbench/brc_ctrl_model.sv
// Controller-side sink of the burst word stream
`timescale 1ns/1ps
module brc_ctrl_model (
  input  wire logic        mclk,
  input  wire logic        slow,
  input  wire logic [21:0] word_addr,
  input  wire logic        word_valid,
  input  wire logic        word_write,
  output logic             word_ready
);
  logic [21:0] got[$];
  logic        wr[$];
  logic        ph_q = 1'b0;
  // Slow mode stalls every other cycle to exercise the hold
  always @(posedge mclk) begin
    ph_q <= ~ph_q;
    if (word_valid && word_ready) begin
      got.push_back(word_addr);
      wr.push_back(word_write);
    end
  end
  assign word_ready = !slow || ph_q;
endmodule : brc_ctrl_model

// File: testbench/testbench.sv
// Self-checking bench for the burst order and refresh configuration block
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [21:0] a; logic act; logic [21:0] lo; logic [21:0] hi;} brc_rrow_s;
  typedef struct packed {logic [2:0] bl; logic w; logic wr; logic [21:0] s;} brc_brow_s;
  logic        mclk        = 1'b0;
  logic        rst_b       = 1'b0;
  logic        cfg_en      = 1'b1;
  logic        acc_strobe  = 1'b0;
  logic        acc_write   = 1'b0;
  logic [21:0] acc_addr    = 22'h0;
  logic [15:0] acc_wdata   = 16'h0;
  logic        burst_start = 1'b0;
  logic        burst_write = 1'b0;
  logic [21:0] burst_addr  = 22'h0;
  logic        burst_stop  = 1'b0;
  logic        slow        = 1'b0;
  logic [15:0] acc_rdata;
  logic        burst_busy, word_valid, word_ready, word_write, page, sleep, ract, wrap;
  logic [21:0] word_addr, rlo, rhi;
  logic [1:0]  temp, lat;
  logic [2:0]  blen;
  int          fail_count  = 0;
  int          checked     = 0;
  brc_rrow_s rr[10] = '{
    '{22'h000070, 1'b1, 22'h0, 22'h3fffff}, '{22'h0000f1, 1'b1, 22'h0, 22'h1fffff},
    '{22'h000012, 1'b1, 22'h0, 22'h0fffff}, '{22'h000033, 1'b1, 22'h0, 22'h07ffff},
    '{22'h000054, 1'b0, 22'h0, 22'h0}, '{22'h000075, 1'b1, 22'h200000, 22'h3fffff},
    '{22'h000076, 1'b1, 22'h300000, 22'h3fffff}, '{22'h000077, 1'b1, 22'h380000, 22'h3fffff},
    '{22'h000067, 1'b0, 22'h0, 22'h0}, '{22'h000070, 1'b1, 22'h0, 22'h3fffff}};
  brc_brow_s br[9] = '{
    '{3'h1, 1'b0, 1'b0, 22'h000001}, '{3'h2, 1'b0, 1'b0, 22'h000005}, '{3'h3, 1'b0, 1'b0, 22'h00000e},
    '{3'h1, 1'b1, 1'b0, 22'h000001}, '{3'h3, 1'b1, 1'b0, 22'h00000f}, '{3'h7, 1'b0, 1'b0, 22'h00000e},
    '{3'h7, 1'b1, 1'b0, 22'h000002}, '{3'h1, 1'b0, 1'b1, 22'h000001}, '{3'h7, 1'b0, 1'b0, 22'h3ffffd}};

  brc_config dut_u (.mclk(mclk), .rst_b(rst_b), .cfg_en(cfg_en), .acc_strobe(acc_strobe), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .burst_start(burst_start),
    .burst_write(burst_write), .burst_addr(burst_addr), .burst_stop(burst_stop), .burst_busy(burst_busy),
    .word_addr(word_addr), .word_valid(word_valid), .word_ready(word_ready), .word_write(word_write),
    .page_read_enable_bit(page), .refresh_temp_threshold(temp), .deep_sleep(sleep), .refresh_active(ract),
    .refresh_lo(rlo), .refresh_hi(rhi), .latency_code(lat), .wrap_select_bit(wrap), .burst_length_field(blen));
  brc_ctrl_model p_u (.mclk(mclk), .slow(slow), .word_addr(word_addr), .word_valid(word_valid),
    .word_write(word_write), .word_ready(word_ready));

  initial begin
    forever #4 mclk = ~mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : chk

  // Inputs pass a two-flop sync, so hold them well around the strobe
  task automatic acc(input logic w, input logic [21:0] a, input logic [15:0] d);
    acc_write <= w;
    acc_addr  <= a;
    acc_wdata <= d;
    cyc(4);
    acc_strobe <= 1'b1;
    cyc(6);
    acc_strobe <= 1'b0;
    cyc(6);
  endtask : acc

  task automatic defaults();
    chk(blen, 3'h7, "blen");
    chk({wrap, lat}, 3'h7, "bus reg");
    chk({page, temp, sleep}, 4'h6, "refresh fields");
    chk({ract, rlo, rhi}, {1'b1, 22'h0, 22'h3fffff}, "window");
    chk({acc_rdata, word_valid}, 17'h0, "outputs");
  endtask : defaults

  function automatic logic [21:0] exp_addr(input brc_brow_s r, input int i);
    logic [21:0] m;
    m = (r.bl == 3'h1) ? 22'h3 : (r.bl == 3'h2) ? 22'h7 : 22'hf;
    if (r.wr || r.w || !(r.bl inside {3'h1, 3'h2, 3'h3})) return r.s + 22'(i);
    return (r.s & ~m) | ((r.s + 22'(i)) & m);
  endfunction : exp_addr

  task automatic burst(input brc_brow_s r, input int k);
    int n;
    int t;
    n = (!r.wr && r.bl inside {3'h1, 3'h2, 3'h3}) ? (2 << r.bl) : 6;
    acc(1'b1, 22'h081800 | {18'h0, r.w, r.bl}, 16'h0);
    chk({lat, wrap, blen}, {2'h3, r.w, r.bl}, "bus fields");
    p_u.got.delete();
    p_u.wr.delete();
    slow        <= k[0];
    burst_addr  <= r.s;
    burst_write <= r.wr;
    burst_start <= 1'b1;
    cyc(4);
    burst_start <= 1'b0;
    for (t = 0; t < 300 && p_u.got.size() < n; t++) cyc(1);
    // Continuous bursts only end on stop; queued words still drain
    if (n == 6) burst_stop <= 1'b1;
    for (t = 0; t < 300 && burst_busy !== 1'b0; t++) cyc(1);
    cyc(40);
    burst_stop <= 1'b0;
    chk(burst_busy, 1'b0, "idle");
    if (n != 6) chk(p_u.got.size(), n, "count");
    chk(p_u.got.size() >= n, 1'b1, "short");
    for (t = 0; t < n && t < p_u.got.size(); t++) begin
      chk(p_u.got[t], exp_addr(r, t), "addr");
      chk(p_u.wr[t], r.wr, "dir");
    end
    $display("burst %0d done", k);
  endtask : burst

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    #(8 * 30000);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    cyc(8);
    rst_b <= 1'b1;
    cyc(1);
    defaults();
    $display("reset test done");
    cyc(6);
    foreach (rr[i]) begin
      acc(1'b1, rr[i].a, 16'h0);
      acc(1'b0, rr[i].a, 16'h0);
      chk(acc_rdata, rr[i].a[15:0], "readback");
      chk({page, temp, sleep}, {rr[i].a[7:5], !rr[i].a[4]}, "fields");
      chk({ract, rlo, rhi}, {rr[i].act, rr[i].lo, rr[i].hi}, "window");
    end
    $display("refresh rows done");
    acc(1'b1, 22'h081000, 16'h0);
    chk({lat, ract, rhi}, {2'h2, 1'b1, 22'h3fffff}, "bus select");
    foreach (br[i]) burst(br[i], i);
    cfg_en <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      acc(1'b0, 22'h3fffff, 16'h0);
      acc(1'b0, 22'h3fffff, 16'h0);
      acc(1'b1, 22'h3fffff, 16'h0000);
      acc(j == 0, 22'h0, 16'h00b5);
    end
    chk(acc_rdata, 16'h00b5, "keyed read");
    chk({page, temp, rlo}, {3'h5, 22'h200000}, "keyed write");
    $display("keyed test done");
    rst_b <= 1'b0;
    cyc(2);
    defaults();
    rst_b <= 1'b1;
    cyc(4);
    $display("second reset done");
    tally_and_finish();
  end
endmodule : testbench
